// file: bst_ctl_model.sv
// Scan controller model: makes the test clock only inside frames.
// Assumes the port samples mode select and data on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module bst_ctl_model (
   output logic      test_clock_in,
   output logic      test_mode_select_in,
   output logic      test_data_in,
   input  wire logic test_data_out
);
   // Idle levels: clock low, mode select high
   initial begin
      test_clock_in       = 1'b0;
      test_mode_select_in = 1'b1;
      test_data_in        = 1'b0;
   end

   // One test clock; data out is taken just before the rising edge
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      test_mode_select_in <= tms;
      test_data_in        <= tdi;
      #80;
      tdo = test_data_out;
      test_clock_in = 1'b1;
      #80;
      test_clock_in = 1'b0;
   endtask

   // Full scan from idle, LSB first, optional pause halfway
   task automatic scan(input logic is_ir, input int n, input logic [31:0] din,
                       input logic pause, output logic [31:0] dout);
      logic b;
      dout = '0;
      #7;
      step(1'b1, 1'b0, b);
      if (is_ir) step(1'b1, 1'b0, b);
      step(1'b0, 1'b0, b);
      step(1'b0, 1'b0, b);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1 || (pause && i == n / 2 - 1), din[i], b);
         dout[i] = b;
         if (pause && i == n / 2 - 1 && i != n - 1) begin
            step(1'b0, 1'b0, b);
            step(1'b0, 1'b0, b);
            step(1'b1, 1'b0, b);
            step(1'b0, 1'b0, b);
         end
      end
      step(1'b1, 1'b0, b);
      step(1'b0, 1'b0, b);
      // Released data line rests high, whatever its last level
      test_data_in <= 1'b1;
   endtask
endmodule
`default_nettype wire

// file: bst_pkg.sv
// Shared constants, state and selection types for the boundary-scan port.
// Assumes a 3-bit instruction register and a 32-bit identification word.
package bst_pkg;

   // Instruction register width and opcodes
   localparam int unsigned IR_W       = 3;
   localparam logic [2:0]  IR_EXTEST  = 3'h0;
   localparam logic [2:0]  IR_IDCODE  = 3'h1;
   localparam logic [2:0]  IR_SAMPLE  = 3'h2;
   localparam logic [2:0]  IR_CLAMP   = 3'h3;
   localparam logic [2:0]  IR_HIGHZ   = 3'h4;
   localparam logic [2:0]  IR_BYPASS  = 3'h7;
   // Fixed pattern loaded in Capture-IR, ends in binary 01
   localparam logic [2:0]  IR_CAPTURE = 3'h1;
   // Value of the instruction latch after reset
   localparam logic [2:0]  IR_RESET   = 3'h1;

   // Identification word layout, LSB first
   localparam int unsigned ID_W        = 32;
   localparam int unsigned ID_MAKER_W  = 11;
   localparam int unsigned ID_PART_W   = 16;
   localparam int unsigned ID_VER_W    = 4;
   localparam logic        ID_FIXED_LSB = 1'b1;

   // Value captured into the bypass cell
   localparam logic        BYP_CAPTURE = 1'b0;

   // Test controller states
   typedef enum logic [3:0] {
      ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
      ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
      ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
   } bst_tap_state_e;

   // Data register chosen by an instruction
   typedef enum logic [1:0] {SEL_BSR, SEL_ID, SEL_BYP} bst_dr_sel_e;

   // Instruction to data register decode
   function automatic bst_dr_sel_e bst_dr_select(input logic [2:0] ir);
      bst_dr_sel_e sel;
      sel = SEL_BYP;
      case (ir)
         IR_EXTEST, IR_SAMPLE: sel = SEL_BSR;
         IR_IDCODE:            sel = SEL_ID;
         default:              sel = SEL_BYP;
      endcase
      return sel;
   endfunction

endpackage

// file: bst_sync.sv
// Two-stage level synchroniser, W bits wide.
// Assumes each bit is a level that is stable for several destination clocks.
`timescale 1ns/1ps
`default_nettype none
module bst_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   // Both stages of the synchroniser
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } bst_sync_s;

   bst_sync_s cur;       // Registered stages
   bst_sync_s next_cur;  // Next stages

   // First stage feeds only the second
   always_comb begin
      next_cur    = cur;
      next_cur.s1 = d;
      next_cur.s2 = cur.s1;
   end

   // Synchronous reset to zero
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign q = cur.s2;
endmodule
`default_nettype wire

// file: bst_tap.sv
// Boundary-scan test access port: controller, instruction register,
// bypass, identification and boundary registers, and pin muxing.
// Assumes the scan controller drives the test clock and the core runs on
// clk_sys; the two clocks are unrelated.
//
// How it works
// - Mode select sampled each rising test clock
// - Power-up: reset state, identification instruction loaded
// - Run-Test-Idle leaves all registers unchanged
// - Select-DR: low captures, high goes Select-IR
// - Capture-DR loads selected register, then branches
// - Shift-DR shifts selected register toward data out
// - Exit1-DR: high updates, low pauses
// - Pause-DR holds registers, exits on high
// - Exit2-DR: high updates, low resumes shifting
// - Update-DR falling edge copies shift to latches
// - Select-IR: low captures, high returns reset
// - Capture-IR loads fixed value, then branches
// - Shift-IR shifts instruction, other registers hold
// - Exit1-IR: low pauses, high updates
// - Pause-IR holds instruction, exits on high
// - Three-bit instruction with shift and latch
// - Update-IR falling edge latches instruction
// - Mandatory opcodes and their selected registers
// - Optional opcodes and their selected registers
// - Sample captures pins, preload via shifting
// - Update-IR branches; latched code becomes current
// - One-bit bypass register for bypass-type instructions
// - Extest drives, clamp holds, highz floats outputs
// - Thirty-two bit identification word captured
`timescale 1ns/1ps
`default_nettype none
module bst_tap
   import bst_pkg::*;
#(
   parameter int unsigned          NUM_IO     = 4,
   parameter logic [ID_VER_W-1:0]  ID_VERSION = 4'h1,     // Arbitrary value
   parameter logic [ID_PART_W-1:0] ID_PART    = 16'h5A3C, // Arbitrary value
   parameter logic [ID_MAKER_W-1:0] ID_MAKER  = 11'h2B6   // Arbitrary value
) (
   input  wire logic              clk_sys,
   input  wire logic              rst_b,
   input  wire logic              test_clock_in,
   input  wire logic              test_reset_in_n,
   input  wire logic              test_mode_select_in,
   input  wire logic              test_data_in,
   output logic                   test_data_out,
   output logic                   test_data_out_oe,
   input  wire logic              legacy_function_select,
   input  wire logic [NUM_IO-1:0] pin_in,
   input  wire logic [NUM_IO-1:0] core_out,
   input  wire logic [NUM_IO-1:0] core_oe,
   output logic      [NUM_IO-1:0] pin_out,
   output logic      [NUM_IO-1:0] pin_oe
);
   // Two boundary cells per pin: data then enable
   localparam int unsigned BSR_W = 2 * NUM_IO;
   localparam int unsigned SYN_W = 2 * NUM_IO + 1;

   // Shift stages, rising test clock
   typedef struct packed {
      logic [IR_W-1:0]  ir_shift;   // Instruction shift stage
      logic [BSR_W-1:0] bsr_shift;  // Boundary shift path
      logic [ID_W-1:0]  id_shift;   // Identification shift path
      logic             byp;        // Bypass cell
   } bst_rise_s;

   // Update latches and data out, falling test clock
   typedef struct packed {
      logic [IR_W-1:0]  ir_par;     // Current instruction
      logic [BSR_W-1:0] bsr_upd;    // Boundary parallel outputs
      logic             tdo;        // Serial out
      logic             tdo_oe;     // Serial out enable
      logic             upd_tgl;    // Flips on each latch update
   } bst_fall_s;

   // Core-side copy and pin drivers, clk_sys
   typedef struct packed {
      logic             tgl_seen;   // Last toggle taken over
      logic [IR_W-1:0]  ir_copy;    // Instruction seen by the core
      logic [BSR_W-1:0] bsr_copy;   // Boundary outputs seen by the core
      logic [NUM_IO-1:0] pout;      // Pin data
      logic [NUM_IO-1:0] poe;       // Pin enable
   } bst_sys_s;

   bst_rise_s      rise;            // Rising-edge state
   bst_rise_s      next_rise;       // Its next value
   bst_fall_s      fall;            // Falling-edge state
   bst_fall_s      next_fall;       // Its next value
   bst_sys_s       sys;             // Core-clock state
   bst_sys_s       next_sys;        // Its next value
   bst_tap_state_e state;           // Controller state
   bst_dr_sel_e    sel;             // Register chosen by instruction
   logic [SYN_W-1:0] tck_syn_q;     // Pins, enables, legacy, test clock side
   logic [1:0]       sys_syn_q;     // Toggle and test reset, core side
   logic [BSR_W-1:0] bsr_cap;       // Capture word for the boundary path
   logic [ID_W-1:0]  id_word;       // Fixed identification word
   logic             legacy_q;      // Synchronised legacy select

   // Controller state machine
   bst_tap_fsm u_fsm (
      .test_clock_in       (test_clock_in),
      .test_reset_in_n     (test_reset_in_n),
      .test_mode_select_in (test_mode_select_in),
      .state               (state)
   );

   // Pins, core enables and legacy select into the test clock domain
   bst_sync #(.W(SYN_W)) u_sync_tck (
      .clk   (test_clock_in),
      .rst_n (test_reset_in_n),
      .d     ({legacy_function_select, core_oe, pin_in}),
      .q     (tck_syn_q)
   );

   // Update toggle and test reset into the core domain
   bst_sync #(.W(2)) u_sync_sys (
      .clk   (clk_sys),
      .rst_n (rst_b),
      .d     ({fall.upd_tgl, test_reset_in_n}),
      .q     (sys_syn_q)
   );

   assign legacy_q = tck_syn_q[SYN_W-1];
   assign sel      = bst_dr_select(fall.ir_par);
   assign id_word  = {ID_VERSION, ID_PART, ID_MAKER, ID_FIXED_LSB};

   // Boundary capture word: pin level and core enable per pin
   for (genvar i = 0; i < NUM_IO; i++) begin : g_cap
      assign bsr_cap[2*i]   = tck_syn_q[i];
      assign bsr_cap[2*i+1] = tck_syn_q[NUM_IO + i];
   end

   // Shift-stage behaviour per controller state
   always_comb begin
      next_rise = rise;
      case (state)
         // Fixed pattern into the instruction stage
         ST_CAP_IR: begin
            next_rise.ir_shift = IR_CAPTURE;
         end
         // Instruction stage shifts, everything else holds
         ST_SHIFT_IR: begin
            next_rise.ir_shift = {test_data_in, rise.ir_shift[IR_W-1:1]};
         end
         // Parallel load of the selected register
         ST_CAP_DR: begin
            case (sel)
               SEL_BSR: next_rise.bsr_shift = bsr_cap;
               SEL_ID:  next_rise.id_shift  = id_word;
               default: next_rise.byp       = BYP_CAPTURE;
            endcase
         end
         // Selected register shifts toward the serial output
         ST_SHIFT_DR: begin
            case (sel)
               SEL_BSR: next_rise.bsr_shift = {test_data_in, rise.bsr_shift[BSR_W-1:1]};
               SEL_ID:  next_rise.id_shift  = {test_data_in, rise.id_shift[ID_W-1:1]};
               default: next_rise.byp       = test_data_in;
            endcase
         end
         // Idle, select, pause, exit and update states hold
         default: begin
            next_rise = rise;
         end
      endcase
   end

   // Shift stages on the rising test clock
   always_ff @(posedge test_clock_in or negedge test_reset_in_n) begin
      if (!test_reset_in_n) begin
         rise <= '0;
      end else begin
         rise <= next_rise;
      end
   end

   // Latch updates and serial output per controller state
   always_comb begin
      next_fall = fall;
      // Reset state forces the identification instruction
      if (state == ST_TLR) begin
         next_fall.ir_par = IR_IDCODE;
         if (fall.ir_par != IR_IDCODE) begin
            next_fall.upd_tgl = ~fall.upd_tgl;
         end
      end
      // Instruction stage becomes the current instruction
      if (state == ST_UPD_IR) begin
         next_fall.ir_par  = rise.ir_shift;
         next_fall.upd_tgl = ~fall.upd_tgl;
      end
      // Boundary shift path copied to its output latches
      if (state == ST_UPD_DR && sel == SEL_BSR) begin
         next_fall.bsr_upd = rise.bsr_shift;
         next_fall.upd_tgl = ~fall.upd_tgl;
      end
      // Serial output from the connected path
      case (state)
         ST_SHIFT_IR: begin
            next_fall.tdo = rise.ir_shift[0];
         end
         ST_SHIFT_DR: begin
            case (sel)
               SEL_BSR: next_fall.tdo = rise.bsr_shift[0];
               SEL_ID:  next_fall.tdo = rise.id_shift[0];
               default: next_fall.tdo = rise.byp;
            endcase
         end
         default: begin
            next_fall.tdo = 1'b0;
         end
      endcase
      // Driven only while shifting and not in the legacy pin role
      next_fall.tdo_oe = (state == ST_SHIFT_IR || state == ST_SHIFT_DR) && !legacy_q;
   end

   // Latches on the falling test clock, reset to identification code
   always_ff @(negedge test_clock_in or negedge test_reset_in_n) begin
      if (!test_reset_in_n) begin
         fall.ir_par  <= IR_RESET;
         fall.bsr_upd <= '0;
         fall.tdo     <= 1'b0;
         fall.tdo_oe  <= 1'b0;
         fall.upd_tgl <= 1'b0;
      end else begin
         fall <= next_fall;
      end
   end

   // Core side: take over latches on each toggle, then drive the pins
   always_comb begin
      next_sys = sys;
      // Latches are stable for many core clocks after a toggle
      if (sys_syn_q[1] != sys.tgl_seen) begin
         next_sys.tgl_seen = sys_syn_q[1];
         next_sys.ir_copy  = fall.ir_par;
         next_sys.bsr_copy = fall.bsr_upd;
      end
      // Test reset, after the two-stage synchroniser, returns pins to normal operation
      if (!sys_syn_q[0]) begin
         next_sys.ir_copy = IR_IDCODE;
      end
      for (int i = 0; i < NUM_IO; i++) begin
         case (sys.ir_copy)
            // Boundary latches drive the pins
            IR_EXTEST, IR_CLAMP: begin
               next_sys.pout[i] = sys.bsr_copy[2*i];
               next_sys.poe[i]  = sys.bsr_copy[2*i+1];
            end
            // All outputs floated
            IR_HIGHZ: begin
               next_sys.pout[i] = 1'b0;
               next_sys.poe[i]  = 1'b0;
            end
            // Core keeps the pins
            default: begin
               next_sys.pout[i] = core_out[i];
               next_sys.poe[i]  = core_oe[i];
            end
         endcase
      end
   end

   // Core-side registers
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         sys.tgl_seen <= 1'b0;
         sys.ir_copy  <= IR_RESET;
         sys.bsr_copy <= '0;
         sys.pout     <= '0;
         sys.poe      <= '0;
      end else begin
         sys <= next_sys;
      end
   end

   assign test_data_out    = fall.tdo;
   assign test_data_out_oe = fall.tdo_oe;
   assign pin_out          = sys.pout;
   assign pin_oe           = sys.poe;

   // Capture-IR loads the fixed pattern
   chk_capture_ir_value: assert property (@(posedge test_clock_in)
      disable iff (!test_reset_in_n)
      (state == ST_CAP_IR) |=> (rise.ir_shift == IR_CAPTURE))
      else $error("Capture-IR pattern wrong");

   // Idle leaves the instruction and boundary shift paths alone
   chk_idle_regs_hold: assert property (@(posedge test_clock_in)
      disable iff (!test_reset_in_n)
      (state == ST_RTI) |=> ($stable(rise.ir_shift) && $stable(rise.bsr_shift)))
      else $error("registers moved in Run-Test-Idle");

   // Identification word captured under its instruction
   chk_id_capture_word: assert property (@(posedge test_clock_in)
      disable iff (!test_reset_in_n)
      (state == ST_CAP_DR && fall.ir_par == IR_IDCODE) |=> (rise.id_shift == id_word))
      else $error("identification word not captured");

   // Bypass cell captures zero
   chk_bypass_capture_zero: assert property (@(posedge test_clock_in)
      disable iff (!test_reset_in_n)
      (state == ST_CAP_DR && fall.ir_par == IR_BYPASS) |=> (rise.byp == BYP_CAPTURE))
      else $error("bypass cell capture wrong");

   // Instruction stage shifts one place per edge
   chk_ir_shift_step: assert property (@(posedge test_clock_in)
      disable iff (!test_reset_in_n)
      (state == ST_SHIFT_IR) |=>
         (rise.ir_shift == {$past(test_data_in), $past(rise.ir_shift[IR_W-1:1])}))
      else $error("instruction shift step wrong");

   // Instruction latched on the falling edge in Update-IR
   chk_ir_update_latch: assert property (@(negedge test_clock_in)
      disable iff (!test_reset_in_n)
      (state == ST_UPD_IR) |=> (fall.ir_par == $past(rise.ir_shift)))
      else $error("instruction latch not updated");

   // Floating instruction releases every pin one core clock after the core copy holds it
   chk_highz_pins_off: assert property (@(posedge clk_sys)
      disable iff (!rst_b)
      (sys.ir_copy == IR_HIGHZ) |=> (sys.poe == '0))
      else $error("pins driven under float instruction");

   // Serial out driven through every data shift in the scan role
   chk_tdo_oe_shift: assert property (@(negedge test_clock_in)
      disable iff (!test_reset_in_n)
      (state == ST_SHIFT_DR && !legacy_q) |=> fall.tdo_oe)
      else $error("serial out not driven in Shift-DR");

   // Boundary latches take the shift path in Update-DR
   chk_bsr_update_latch: assert property (@(negedge test_clock_in)
      disable iff (!test_reset_in_n)
      (state == ST_UPD_DR && sel == SEL_BSR) |=> (fall.bsr_upd == $past(rise.bsr_shift)))
      else $error("boundary latches not updated");

   // Identification path shifts one place per edge
   chk_id_shift_step: assert property (@(posedge test_clock_in)
      disable iff (!test_reset_in_n)
      (state == ST_SHIFT_DR && sel == SEL_ID) |=>
         (rise.id_shift == {$past(test_data_in), $past(rise.id_shift[ID_W-1:1])}))
      else $error("identification shift step wrong");
endmodule
`default_nettype wire

// file: bst_tap_fsm.sv
// Sixteen-state test controller, advancing on rising test clock edges.
// Assumes mode select is synchronous to the test clock.
`timescale 1ns/1ps
`default_nettype none
module bst_tap_fsm
   import bst_pkg::*;
(
   input  wire logic     test_clock_in,
   input  wire logic     test_reset_in_n,
   input  wire logic     test_mode_select_in,
   output var bst_tap_state_e state
);
   // Controller state record
   typedef struct packed {
      bst_tap_state_e st;
   } bst_fsm_s;

   bst_fsm_s cur;       // Current state
   bst_fsm_s next_cur;  // Next state
   logic     tms;       // Short name for mode select

   assign tms = test_mode_select_in;

   // Transition table
   always_comb begin
      next_cur = cur;
      case (cur.st)
         ST_TLR:      next_cur.st = tms ? ST_TLR      : ST_RTI;
         ST_RTI:      next_cur.st = tms ? ST_SEL_DR   : ST_RTI;
         ST_SEL_DR:   next_cur.st = tms ? ST_SEL_IR   : ST_CAP_DR;
         ST_CAP_DR:   next_cur.st = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_SHIFT_DR: next_cur.st = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_EXIT1_DR: next_cur.st = tms ? ST_UPD_DR   : ST_PAUSE_DR;
         ST_PAUSE_DR: next_cur.st = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
         ST_EXIT2_DR: next_cur.st = tms ? ST_UPD_DR   : ST_SHIFT_DR;
         ST_UPD_DR:   next_cur.st = tms ? ST_SEL_DR   : ST_RTI;
         ST_SEL_IR:   next_cur.st = tms ? ST_TLR      : ST_CAP_IR;
         ST_CAP_IR:   next_cur.st = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_SHIFT_IR: next_cur.st = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_EXIT1_IR: next_cur.st = tms ? ST_UPD_IR   : ST_PAUSE_IR;
         ST_PAUSE_IR: next_cur.st = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
         ST_EXIT2_IR: next_cur.st = tms ? ST_UPD_IR   : ST_SHIFT_IR;
         ST_UPD_IR:   next_cur.st = tms ? ST_SEL_DR   : ST_RTI;
         default:     next_cur.st = ST_TLR;
      endcase
   end

   // Advance on each rising edge, test reset acts at once
   always_ff @(posedge test_clock_in or negedge test_reset_in_n) begin
      if (!test_reset_in_n) begin
         cur.st <= ST_TLR;
      end else begin
         cur <= next_cur;
      end
   end

   assign state = cur.st;

   // Five high mode-select samples always reach reset
   chk_five_ones_reset: assert property (@(posedge test_clock_in)
      disable iff (!test_reset_in_n) tms [*5] |=> cur.st == ST_TLR)
      else $error("five high mode-select did not reach reset");

   // Select-DR with high mode select goes to Select-IR
   chk_sel_dr_branch: assert property (@(posedge test_clock_in)
      disable iff (!test_reset_in_n)
      (cur.st == ST_SEL_DR) |=> (cur.st == ($past(tms) ? ST_SEL_IR : ST_CAP_DR)))
      else $error("wrong exit from Select-DR");

   // Pause-DR holds while mode select stays low
   chk_pause_dr_hold: assert property (@(posedge test_clock_in)
      disable iff (!test_reset_in_n)
      (cur.st == ST_PAUSE_DR && !tms) |=> (cur.st == ST_PAUSE_DR))
      else $error("Pause-DR left with low mode select");

   // Exit1-IR routes to update or pause
   chk_exit1_ir_branch: assert property (@(posedge test_clock_in)
      disable iff (!test_reset_in_n)
      (cur.st == ST_EXIT1_IR) |=> (cur.st == ($past(tms) ? ST_UPD_IR : ST_PAUSE_IR)))
      else $error("wrong exit from Exit1-IR");
endmodule
`default_nettype wire

// file: bst_tap_tb.sv
// Self-checking bench for the boundary-scan port.
// Assumes the scan controller model drives the test-side pins.
`timescale 1ns/1ps
`default_nettype none
module bst_tap_tb;
   import bst_pkg::*;
   localparam logic [31:0] ID_WORD = {4'h1, 16'h5A3C, 11'h2B6, 1'b1}; // Arbitrary
   localparam logic [7:0]  PRELOAD = 8'h96; // Boundary word shifted in
   logic       clk_sys, rst_b, test_reset_in_n, legacy_function_select;
   wire logic  test_clock_in, test_mode_select_in, test_data_in;
   logic       test_data_out, test_data_out_oe;
   logic [3:0] pin_in, core_out, core_oe, pin_out, pin_oe;
   logic [31:0] d, e;
   logic       b;
   int         miscompares, samples_checked;
   int         oe_edges = 0;

   // Device under test, identity values arbitrary
   bst_tap #(.NUM_IO(4), .ID_VERSION(4'h1), .ID_PART(16'h5A3C), .ID_MAKER(11'h2B6)) DUT (
      .clk_sys, .rst_b, .test_clock_in, .test_reset_in_n, .test_mode_select_in,
      .test_data_in, .test_data_out, .test_data_out_oe, .legacy_function_select,
      .pin_in, .core_out, .core_oe, .pin_out, .pin_oe);

   // Far-side scan controller
   bst_ctl_model u_ctl (.test_clock_in, .test_mode_select_in, .test_data_in,
                        .test_data_out);

   // Rising test clock edges that find serial out driven
   always @(posedge test_clock_in) begin
      if (test_data_out_oe) oe_edges <= oe_edges + 1;
   end

   // Core clock, 40 ns
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // Compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Verdict and end of run
   task automatic report_and_stop();
      if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Load an instruction, let the pins settle
   task automatic load_ir(input logic [2:0] op);
      u_ctl.scan(1'b1, 3, {29'h0, op}, 1'b0, d);
      repeat (5) @(posedge clk_sys);
   endtask

   // Instruction, then pin levels
   task automatic mode_pins(input logic [2:0] op, input logic [3:0] eo, input logic [3:0] ee);
      load_ir(op);
      check({24'h0, pin_out, pin_oe}, {24'h0, eo, ee});
   endtask

   // Power-up instruction, capture pattern, identification word
   task automatic t_power_up();
      int oe0;
      check({28'h0, pin_out}, 32'h5);
      oe0 = oe_edges;
      u_ctl.scan(1'b0, 32, 32'h0, 1'b0, d);
      check(d, ID_WORD);
      check(oe_edges - oe0, 32'h20);
      oe0 = oe_edges;
      u_ctl.scan(1'b1, 3, {29'h0, IR_IDCODE}, 1'b0, d);
      check(d, 32'h1);
      check(oe_edges - oe0, 32'h3);
   endtask

   // Bypass and undefined codes: one-cell delay
   task automatic t_bypass();
      logic [2:0] ops [3] = '{IR_BYPASS, 3'h5, 3'h6};
      foreach (ops[k]) begin
         load_ir(ops[k]);
         u_ctl.scan(1'b0, 8, 32'hB4, 1'b0, d);
         check(d, {24'h0, 7'h34, BYP_CAPTURE});
      end
   endtask

   // Boundary capture, paused shift, update to pins
   task automatic t_extest();
      pin_in <= 4'hC;
      load_ir(IR_EXTEST);
      u_ctl.scan(1'b0, 8, {24'h0, PRELOAD}, 1'b1, d);
      e = '0;
      for (int i = 0; i < 4; i++) begin
         e[2*i]   = pin_in[i];
         e[2*i+1] = core_oe[i];
      end
      check(d, e);
      repeat (4) @(posedge clk_sys);
      for (int i = 0; i < 4; i++) begin
         e[i]   = PRELOAD[2*i];
         e[i+4] = PRELOAD[2*i+1];
      end
      check({24'h0, pin_out, pin_oe}, {24'h0, e[3:0], e[7:4]});
   endtask

   // Test reset mid-run returns to the identification instruction
   task automatic t_test_reset();
      load_ir(IR_BYPASS);
      @(posedge clk_sys);
      test_reset_in_n <= 1'b0;
      repeat (3) u_ctl.step(1'b0, 1'b0, b);
      @(posedge clk_sys);
      test_reset_in_n <= 1'b1;
      u_ctl.step(1'b0, 1'b0, b);
      u_ctl.scan(1'b0, 32, 32'h0, 1'b0, d);
      check(d, ID_WORD);
   endtask

   // Legacy role: serial out stays undriven while the scan runs inside
   task automatic t_legacy();
      int oe0;
      oe0 = oe_edges;
      legacy_function_select <= 1'b1;
      load_ir(IR_IDCODE);
      check(oe_edges - oe0, 32'h0);
      legacy_function_select <= 1'b0;
      u_ctl.scan(1'b0, 32, 32'h0, 1'b0, d);
      check(d, ID_WORD);
      check(oe_edges - oe0, 32'h20);
   endtask

   // Main sequence
   initial begin
      miscompares = 0;
      samples_checked = 0;
      rst_b = 1'b0;
      test_reset_in_n = 1'b0;
      legacy_function_select = 1'b0;
      pin_in = 4'h0;
      core_out = 4'h5;
      core_oe = 4'h3;
      repeat (3) u_ctl.step(1'b1, 1'b0, b);
      @(posedge clk_sys);
      rst_b <= 1'b1;
      test_reset_in_n <= 1'b1;
      u_ctl.step(1'b0, 1'b0, b);
      repeat (5) @(posedge clk_sys);
      t_power_up();
      t_bypass();
      t_extest();
      mode_pins(IR_CLAMP, 4'h6, 4'h9);
      mode_pins(IR_HIGHZ, 4'h0, 4'h0);
      mode_pins(IR_SAMPLE, 4'h5, 4'h3);
      t_test_reset();
      t_legacy();
      report_and_stop();
   end

   // Watchdog
   initial begin
      #1000000;
      miscompares++;
      report_and_stop();
   end
endmodule
`default_nettype wire
